// >>> jtag_char_pkg.sv
package jtag_char_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register addresses, full 32-bit byte addresses
	localparam logic [31:0] DATA_REG_ADDR  = 32'hFF20_1000;
	localparam logic [31:0] CTRL_REG_ADDR  = 32'hFF20_1004;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int          CHAR_W         = 8;
	localparam int          COUNT_LSB      = 16;
	localparam int          COUNT_W        = 16;
	localparam int          RX_VALID_BIT   = 15;
	localparam int          HOST_ACC_BIT   = 10;
	localparam int          TX_PEND_BIT    = 9;
	localparam int          RX_PEND_BIT    = 8;
	localparam int          TX_EN_BIT      = 1;
	localparam int          RX_EN_BIT      = 0;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and thresholds
	localparam logic        IRQ_EN_RESET   = 1'h0;
	localparam logic        HOST_ACC_RESET = 1'h0;
	localparam logic [15:0] IRQ_THRESHOLD  = 16'h0007;
	localparam int          QUEUE_DEPTH    = 64;

endpackage

// >>> jtag_host_char_uart.sv
`timescale 1ns/1ps
module jtag_host_char_uart #(
	parameter int DEPTH = jtag_char_pkg::QUEUE_DEPTH
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst_n,
	input  wire logic [31:0]                      reg_addr,
	input  wire logic                             reg_rd,
	input  wire logic                             reg_wr,
	input  wire logic [31:0]                      reg_wdata,
	output logic      [31:0]                      reg_rdata,
	output logic                                  reg_rvalid,
	output logic                                  irq,
	input  wire logic                             clk_link,
	input  wire logic                             link_rx_valid,
	input  wire logic [jtag_char_pkg::CHAR_W-1:0] link_rx_data,
	output logic                                  link_tx_valid,
	output logic      [jtag_char_pkg::CHAR_W-1:0] link_tx_data,
	input  wire logic                             link_tx_ready
);
	import jtag_char_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	typedef logic [PW-1:0] ptr_t;
	localparam ptr_t DEPTH_P = ptr_t'(DEPTH);

	function automatic ptr_t bin2gray(input ptr_t b);
		return b ^ (b >> 1);
	endfunction
	function automatic ptr_t gray2bin(input ptr_t g);
		ptr_t b;
		b = g;
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction
	function automatic logic [COUNT_W-1:0] widen(input ptr_t p);
		return {{(COUNT_W-PW){1'b0}}, p};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register decode
	logic acc_data_rd;
	logic acc_data_wr;
	logic acc_ctrl_rd;
	logic acc_ctrl_wr;
	assign acc_data_rd = reg_rd && (reg_addr == DATA_REG_ADDR);
	assign acc_data_wr = reg_wr && (reg_addr == DATA_REG_ADDR);
	assign acc_ctrl_rd = reg_rd && (reg_addr == CTRL_REG_ADDR);
	assign acc_ctrl_wr = reg_wr && (reg_addr == CTRL_REG_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// receive queue: written on clk_link, drained on clk_sys
	logic [CHAR_W-1:0] rx_mem [DEPTH];
	ptr_t              rx_wptr;
	ptr_t              rx_wgray;
	ptr_t              rx_rptr;
	ptr_t              rx_rgray;
	ptr_t              rx_rgray_m;
	ptr_t              rx_rgray_s;
	ptr_t              rx_wgray_m;
	ptr_t              rx_wgray_s;
	ptr_t              rx_fill_count;
	logic              rx_full;
	logic              rx_push;
	logic              rx_empty;
	logic              rx_pop;
	// the link side sees the read pointer late, so full is pessimistic, never wrong
	assign rx_full = (ptr_t'(rx_wptr - gray2bin(rx_rgray_s)) == DEPTH_P);
	assign rx_push = link_rx_valid && !rx_full;

	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			rx_wptr  <= '0;
			rx_wgray <= '0;
		end else if (rx_push) begin
			rx_wptr  <= ptr_t'(rx_wptr + 1'b1);
			rx_wgray <= bin2gray(ptr_t'(rx_wptr + 1'b1));
		end
	end
	always_ff @(posedge clk_link) begin
		if (rx_push) begin
			rx_mem[rx_wptr[AW-1:0]] <= link_rx_data;
		end
	end
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			rx_rgray_m <= '0;
			rx_rgray_s <= '0;
		end else begin
			rx_rgray_m <= rx_rgray;
			rx_rgray_s <= rx_rgray_m;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_wgray_m <= '0;
			rx_wgray_s <= '0;
		end else begin
			rx_wgray_m <= rx_wgray;
			rx_wgray_s <= rx_wgray_m;
		end
	end
	assign rx_fill_count = ptr_t'(gray2bin(rx_wgray_s) - rx_rptr);
	assign rx_empty      = (rx_fill_count == '0);
	assign rx_pop        = acc_data_rd && !rx_empty;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_rptr  <= '0;
			rx_rgray <= '0;
		end else if (rx_pop) begin
			rx_rptr  <= ptr_t'(rx_rptr + 1'b1);
			rx_rgray <= bin2gray(ptr_t'(rx_rptr + 1'b1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit queue: filled on clk_sys, drained on clk_link
	logic [CHAR_W-1:0] tx_mem [DEPTH];
	ptr_t              tx_wptr;
	ptr_t              tx_wgray;
	ptr_t              tx_rptr;
	ptr_t              tx_rgray;
	ptr_t              tx_rgray_m;
	ptr_t              tx_rgray_s;
	ptr_t              tx_wgray_m;
	ptr_t              tx_wgray_s;
	ptr_t              tx_free_space;
	ptr_t              next_tx_rptr;
	logic              tx_full;
	logic              tx_push;
	logic              tx_take;
	assign tx_free_space = ptr_t'(DEPTH_P - ptr_t'(tx_wptr - gray2bin(tx_rgray_s)));
	assign tx_full       = (tx_free_space == '0);
	assign tx_push       = acc_data_wr && !tx_full;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_wptr  <= '0;
			tx_wgray <= '0;
		end else if (tx_push) begin
			tx_wptr  <= ptr_t'(tx_wptr + 1'b1);
			tx_wgray <= bin2gray(ptr_t'(tx_wptr + 1'b1));
		end
	end
	always_ff @(posedge clk_sys) begin
		if (tx_push) begin
			tx_mem[tx_wptr[AW-1:0]] <= reg_wdata[CHAR_W-1:0];
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_rgray_m <= '0;
			tx_rgray_s <= '0;
		end else begin
			tx_rgray_m <= tx_rgray;
			tx_rgray_s <= tx_rgray_m;
		end
	end
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			tx_wgray_m <= '0;
			tx_wgray_s <= '0;
		end else begin
			tx_wgray_m <= tx_wgray;
			tx_wgray_s <= tx_wgray_m;
		end
	end
	// head is presented from flops; the pointer moves only when the host takes it
	assign tx_take      = link_tx_valid && link_tx_ready;
	assign next_tx_rptr = tx_take ? ptr_t'(tx_rptr + 1'b1) : tx_rptr;
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			tx_rptr       <= '0;
			tx_rgray      <= '0;
			link_tx_valid <= 1'b0;
			link_tx_data  <= '0;
		end else begin
			tx_rptr       <= next_tx_rptr;
			tx_rgray      <= bin2gray(next_tx_rptr);
			link_tx_valid <= (next_tx_rptr != gray2bin(tx_wgray_s));
			link_tx_data  <= tx_mem[next_tx_rptr[AW-1:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// host activity: toggle on the link, edge seen on clk_sys
	logic acc_tgl;
	logic acc_tgl_m;
	logic acc_tgl_s;
	logic acc_tgl_d;
	logic host_evt;
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			acc_tgl <= 1'b0;
		end else if (link_rx_valid || tx_take) begin
			acc_tgl <= !acc_tgl;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_tgl_m <= 1'b0;
			acc_tgl_s <= 1'b0;
			acc_tgl_d <= 1'b0;
		end else begin
			acc_tgl_m <= acc_tgl;
			acc_tgl_s <= acc_tgl_m;
			acc_tgl_d <= acc_tgl_s;
		end
	end
	assign host_evt = acc_tgl_s ^ acc_tgl_d;

	////////////////////////////////////////////////////////////////////////////////
	// control register state
	logic host_accessed_flag;
	logic rx_irq_enable;
	logic tx_irq_enable;
	logic rx_irq_pending;
	logic tx_irq_pending;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			host_accessed_flag <= HOST_ACC_RESET;
		end else if (host_evt) begin
			host_accessed_flag <= 1'b1;
		end else if (acc_ctrl_wr && reg_wdata[HOST_ACC_BIT]) begin
			host_accessed_flag <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq_enable <= IRQ_EN_RESET;
			tx_irq_enable <= IRQ_EN_RESET;
		end else if (acc_ctrl_wr) begin
			rx_irq_enable <= reg_wdata[RX_EN_BIT];
			tx_irq_enable <= reg_wdata[TX_EN_BIT];
		end
	end
	// level conditions: they fall as soon as data traffic pulls the counts back
	assign rx_irq_pending = rx_irq_enable && (widen(rx_fill_count) > IRQ_THRESHOLD);
	assign tx_irq_pending = tx_irq_enable && (widen(tx_free_space) > IRQ_THRESHOLD);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= rx_irq_pending || tx_irq_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		if (acc_data_rd) begin
			next_rdata[COUNT_LSB +: COUNT_W] = widen(rx_empty ? rx_fill_count
				: ptr_t'(rx_fill_count - 1'b1));
			next_rdata[RX_VALID_BIT]         = !rx_empty;
			next_rdata[CHAR_W-1:0]           = rx_mem[rx_rptr[AW-1:0]];
		end else if (acc_ctrl_rd) begin
			next_rdata[COUNT_LSB +: COUNT_W] = widen(tx_free_space);
			next_rdata[HOST_ACC_BIT]         = host_accessed_flag;
			next_rdata[TX_PEND_BIT]          = tx_irq_pending;
			next_rdata[RX_PEND_BIT]          = rx_irq_pending;
			next_rdata[TX_EN_BIT]            = tx_irq_enable;
			next_rdata[RX_EN_BIT]            = rx_irq_enable;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= next_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	chk_rx_full_drop: assert property (@(posedge clk_link) disable iff (!rst_n)
		link_rx_valid && rx_full |=> rx_wptr == $past(rx_wptr))
		else $error("receive queue advanced while full");
	chk_rx_push_step: assert property (@(posedge clk_link) disable iff (!rst_n)
		link_rx_valid && !rx_full |=> rx_wptr == ptr_t'($past(rx_wptr) + 1'b1))
		else $error("accepted host character not queued");
	chk_rx_pop_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_data_rd && !rx_empty |=> reg_rvalid && reg_rdata[RX_VALID_BIT]
			&& reg_rdata[31:16] == widen(ptr_t'($past(rx_fill_count) - 1'b1)))
		else $error("data read did not return decremented count");
	chk_rx_empty_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_data_rd && rx_empty |=> reg_rvalid && !reg_rdata[RX_VALID_BIT]
			&& rx_rptr == $past(rx_rptr))
		else $error("empty read marked valid or popped");
	chk_wr_keeps_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_data_wr && !reg_rd |=> rx_rptr == $past(rx_rptr))
		else $error("data write disturbed receive queue");
	chk_tx_push_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_data_wr |=> tx_wptr == ptr_t'($past(tx_wptr) + ($past(tx_full) ? 1'b0 : 1'b1)))
		else $error("transmit push wrong for fill state");
	chk_host_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		host_evt |=> host_accessed_flag)
		else $error("host access not flagged");
	chk_host_flag_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_ctrl_wr && reg_wdata[HOST_ACC_BIT] && !host_evt |=> !host_accessed_flag)
		else $error("host access flag not cleared by write of one");
	chk_ctrl_read_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		acc_ctrl_rd && !reg_wr |=> $stable(rx_rptr) && $stable(tx_wptr)
			&& reg_rdata[14:11] == 4'h0 && reg_rdata[7:2] == 6'h00)
		else $error("control read had side effect or reserved bits set");
	chk_irq_threshold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_irq_enable && rx_fill_count > ptr_t'(IRQ_THRESHOLD) |=> irq)
		else $error("interrupt missing above threshold");

endmodule // jtag_host_char_uart

// >>> link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
	input  wire logic       clk_link,
	input  wire logic       hold,
	output logic            link_rx_valid,
	output logic      [7:0] link_rx_data,
	input  wire logic       link_tx_valid,
	input  wire logic [7:0] link_tx_data,
	output logic            link_tx_ready
);
	logic [7:0] got_q[$];

	initial begin
		link_rx_valid = 1'b0;
		link_rx_data  = 8'h00;
		link_tx_ready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// host typing: one pulse per character, the device cannot push back
	task automatic send(input logic [7:0] c);
		@(negedge clk_link);
		link_rx_valid = 1'b1;
		link_rx_data  = c;
		@(negedge clk_link);
		link_rx_valid = 1'b0;
		link_rx_data  = ~c; // line no longer qualified, so never show the old value
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// host reading: slow or prompt at random, fully stalled while hold is high
	always @(negedge clk_link) begin
		link_tx_ready <= !hold && ($urandom_range(0, 3) != 0);
	end

	always @(posedge clk_link) begin
		if (link_tx_valid && link_tx_ready) begin
			got_q.push_back(link_tx_data);
		end
	end
endmodule // link_host_model

// >>> jtag_host_char_uart_test.sv
`timescale 1ns/1ps
module jtag_host_char_uart_test;
	import jtag_char_pkg::*;
	// short queues keep the full and overflow cases quick
	localparam int D = 8;
	typedef struct packed {logic [31:0] exp; logic [31:0] mask;} note_s;

	logic        clk_sys;
	logic        rst_n;
	logic        clk_link;
	logic        hold;
	logic [31:0] reg_addr;
	logic        reg_rd;
	logic        reg_wr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_rvalid;
	logic        irq;
	logic        link_rx_valid;
	logic [7:0]  link_rx_data;
	logic        link_tx_valid;
	logic [7:0]  link_tx_data;
	logic        link_tx_ready;
	note_s       notes[$];
	note_s       n;
	logic [7:0]  tx_model[$];
	logic [7:0]  rx_model[$];
	logic [7:0]  c;
	logic [31:0] w;
	int          mismatches;
	int          comparisons;
	int          cycles;
	int          seed;

	jtag_host_char_uart #(.DEPTH(D)) jtag_host_char_uart_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .irq(irq), .clk_link(clk_link),
		.link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
		.link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data),
		.link_tx_ready(link_tx_ready));

	link_host_model link_host_model_i (
		.clk_link(clk_link), .hold(hold), .link_rx_valid(link_rx_valid),
		.link_rx_data(link_rx_data), .link_tx_valid(link_tx_valid),
		.link_tx_data(link_tx_data), .link_tx_ready(link_tx_ready));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		clk_link = 1'b0;
		#37;
		forever #62.5 clk_link = ~clk_link;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		comparisons++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got & m, exp & m);
		end
	endtask

	task automatic cmp_char(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge clk_sys);
		reg_wr    = 1'b0;
	endtask

	// the expectation is noted first, the watcher below settles it
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back(note_s'{e, m});
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clk_sys);
		reg_rd   = 1'b0;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(negedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (notes.size() == 0) begin
				n = note_s'{32'hFFFF_FFFF, 32'h0000_0000};
				mismatches++;
				$display("wrong value at %0t: got %h expected %h", $time, reg_rdata, 32'h0);
			end else begin
				n = notes.pop_front();
				cmp_word(reg_rdata, n.exp, n.mask);
			end
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0; reg_addr = 32'h0000_0000; reg_rd = 1'b0; reg_wr = 1'b0;
		reg_wdata = 32'h0000_0000; hold = 1'b1;
		seed = $urandom(35850);
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(CTRL_REG_ADDR, {16'(D), 16'h0000}, 32'hFFFF_FFFF);
		rd(DATA_REG_ADDR, 32'h0000_0000, 32'hFFFF_FF00);
		rd(32'hFF20_1008, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("reset values test done");
		for (int i = 0; i < D + 2; i++) begin
			c = 8'($urandom);
			if (i < D) rx_model.push_back(c);
			link_host_model_i.send(c);
		end
		repeat (10) @(negedge clk_sys);
		wr(CTRL_REG_ADDR, 32'h0000_0001);
		rd(CTRL_REG_ADDR, {16'(D), 16'h0501}, 32'hFFFF_FFFF);
		repeat (2) @(negedge clk_sys);
		cmp_word({31'h0, irq}, 32'h0000_0001, 32'h0000_0001);
		w = $urandom;
		tx_model.push_back(w[7:0]);
		wr(DATA_REG_ADDR, w);
		for (int i = 0; i <= D; i++) begin
			if (rx_model.size() > 0) begin
				c = rx_model.pop_front();
				rd(DATA_REG_ADDR, {16'(rx_model.size()), 8'h80, c}, 32'hFFFF_FFFF);
			end else begin
				rd(DATA_REG_ADDR, 32'h0000_0000, 32'hFFFF_FF00);
			end
			if (i == 0) rd(CTRL_REG_ADDR, {16'(D - 1), 16'h0401}, 32'hFFFF_FFFF);
		end
		$display("receive queue test done");
		// software would test free space first; here the full queue is overrun on purpose
		for (int i = 0; i < D + 1; i++) begin
			w = $urandom;
			if (tx_model.size() < D) tx_model.push_back(w[7:0]);
			wr(DATA_REG_ADDR, w);
		end
		repeat (10) @(negedge clk_sys);
		rd(CTRL_REG_ADDR, 32'h0000_0401, 32'hFFFF_FFFF);
		wr(CTRL_REG_ADDR, 32'h0000_0402);
		rd(CTRL_REG_ADDR, 32'h0000_0002, 32'hFFFF_FFFF);
		hold = 1'b0;
		for (int k = 0; k < 2000 && link_host_model_i.got_q.size() < D; k++) @(negedge clk_sys);
		repeat (10) @(negedge clk_sys);
		rd(CTRL_REG_ADDR, {16'(D), 16'h0602}, 32'hFFFF_FFFF);
		cmp_word(32'(link_host_model_i.got_q.size()), 32'(D), 32'hFFFF_FFFF);
		foreach (tx_model[i]) begin
			if (i < link_host_model_i.got_q.size())
				cmp_char(link_host_model_i.got_q[i], tx_model[i]);
		end
		wr(CTRL_REG_ADDR, 32'h0000_0400);
		rd(CTRL_REG_ADDR, {16'(D), 16'h0000}, 32'hFFFF_FFFF);
		repeat (4) @(negedge clk_sys);
		cmp_word({31'h0, irq}, 32'h0000_0000, 32'h0000_0001);
		$display("transmit queue test done");
		finish_test();
	end
endmodule // jtag_host_char_uart_test
